// ==== pkg/rpm_pkg.sv ====
// Package with constants and carriers for the remappable pin matrix
package rpm_pkg;
  // ---------------------------------------------------------------
  // Field and index sizes
  // ---------------------------------------------------------------
  localparam int unsigned SEL_W      = 6;   // Every select field
  localparam int unsigned IDX_SPACE  = 64;  // Pins addressable by a field
  localparam int unsigned NUM_IO     = 32;  // Output-capable pins 0..31
  localparam int unsigned NUM_PINS   = 44;  // Largest variant, 12 input-only
  localparam int unsigned NUM_IN     = 36;  // Pin-selectable peripheral inputs
  localparam int unsigned NUM_FUNC   = 36;  // Highest output function code
  localparam int unsigned IN_IDX_W   = 6;   // Peripheral input index width

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [5:0] OUT_SEL_RST = 6'h00; // Null output
  localparam logic [5:0] IN_SEL_RST  = 6'h3f; // Ties input low
  localparam logic [5:0] LAST_PIN    = 6'h2b; // Highest implemented index
  localparam logic [5:0] LAST_FUNC   = 6'h24; // Comparator three
  // Codes carrying a function: 1-12, 18-25, 28-36
  localparam logic [63:0] LISTED_MASK = 64'h0000_001f_f3fc_1ffe;
  // All 44 pins present in the largest variant
  localparam logic [43:0] ALL_PINS   = 44'hfff_ffff_ffff;

  // Write request into one select field
  typedef struct packed {
    logic       en;
    logic [5:0] idx;
    logic [5:0] code;
  } rpm_wr_t;

  // Output code that routes a peripheral output
  function automatic logic rpm_code_listed(input logic [5:0] code);
    return LISTED_MASK[code];
  endfunction
endpackage

// ==== design/rpm_matrix.sv ====
// Remappable pin matrix: output select per pin, input select per input
//
// Overview of operation
// - Each io pin owns a 6-bit output select
// - Code zero disconnects pin from all outputs
// - Reset clears every output select to zero
// - Codes 1-6: comparators, uart one/two signals
// - Codes 7-12: spi one and two outputs
// - Codes 18-25 compare units, 28-31 uarts three/four
// - Codes 32-34 spi three, 35 compare nine, 36 comparator
// - Structure blocks contention on pins and inputs
// - Fan-out of pins and outputs allowed
// - Six-bit index space addresses 64 pins
// - At most 44 pins, 12 input only
// - Present pins set by a parameter mask
// - Unimplemented or above-43 input codes give nothing
// - Fields of absent pins have no storage
// - Each peripheral input owns a pin index field
// - Pins 0-31 io, 32 upward input only
// - Reset loads input selects with all ones
// - Lock set makes select writes vanish
`timescale 1ns/1ps
module rpm_matrix #(
  parameter logic [43:0] PIN_PRESENT = rpm_pkg::ALL_PINS
) (
  // Clock and reset
  input  wire logic                            i_clk,
  input  wire logic                            i_rst,
  // Write lock and select writes
  input  wire logic                            i_pin_map_write_lock,
  input  wire rpm_pkg::rpm_wr_t                i_out_sel_wr,
  input  wire rpm_pkg::rpm_wr_t                i_in_sel_wr,
  // Peripheral outputs, bit n is function code n
  input  wire logic [rpm_pkg::NUM_FUNC:1]      i_func_out,
  // Remappable pin levels from the pads
  input  wire logic [rpm_pkg::NUM_PINS-1:0]    i_pin_in,
  // Pad drive for io pins, enable low while driving
  output logic      [rpm_pkg::NUM_IO-1:0]      o_pin_out,
  output logic      [rpm_pkg::NUM_IO-1:0]      o_pin_oe_n,
  // Peripheral inputs, bit n is input index n
  output logic      [rpm_pkg::NUM_IN-1:0]      o_periph_in
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [rpm_pkg::NUM_IO-1:0][5:0]   out_sel_q;
  logic [rpm_pkg::NUM_IN-1:0][5:0]   in_sel_q;
  logic [rpm_pkg::NUM_PINS-1:0]      pin_meta_q;
  logic [rpm_pkg::NUM_PINS-1:0]      pin_sync_q;
  logic [rpm_pkg::NUM_IO-1:0]        pin_out_q;
  logic [rpm_pkg::NUM_IO-1:0]        pin_oe_n_q;
  logic [rpm_pkg::NUM_IN-1:0]        periph_in_q;
  logic [rpm_pkg::IDX_SPACE-1:0]     pin_valid;
  logic [rpm_pkg::IDX_SPACE-1:0]     pin_level;
  logic [rpm_pkg::NUM_FUNC:0]        func_vec;
  logic                              out_wr_ok;
  logic                              in_wr_ok;

  assign o_pin_out   = pin_out_q;
  assign o_pin_oe_n  = pin_oe_n_q;
  assign o_periph_in = periph_in_q;

  // Code 0 carries a constant low so the null code reads cleanly
  assign func_vec = {i_func_out, 1'b0};

  // Indices past the last pin are never valid; all ones selects no pin
  assign pin_valid = {20'h00000, PIN_PRESENT};
  assign pin_level = {20'h00000, pin_sync_q};

  // Locked writes still look accepted to the writer
  assign out_wr_ok = i_out_sel_wr.en && !i_pin_map_write_lock;
  assign in_wr_ok  = i_in_sel_wr.en && !i_pin_map_write_lock;

  // ---------------------------------------------------------------
  // Pad synchronisers
  // ---------------------------------------------------------------
  // Pads are asynchronous to the system clock
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= i_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Output select fields, one per io pin
  // ---------------------------------------------------------------
  for (genvar p = 0; p < rpm_pkg::NUM_IO; p++) begin : g_out
    if (PIN_PRESENT[p]) begin : g_field
      // Only io indices 0..31 can hit a field
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          out_sel_q[p] <= rpm_pkg::OUT_SEL_RST;
        end else if (out_wr_ok && i_out_sel_wr.idx == 6'(p)) begin
          out_sel_q[p] <= i_out_sel_wr.code;
        end
      end
    end else begin : g_absent
      // No storage: writes land nowhere
      assign out_sel_q[p] = rpm_pkg::OUT_SEL_RST;
    end

    // One code per pin means two outputs can never share it
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        pin_out_q[p]  <= 1'b0;
        pin_oe_n_q[p] <= 1'b1;
      end else if (rpm_pkg::rpm_code_listed(out_sel_q[p])) begin
        pin_out_q[p]  <= func_vec[out_sel_q[p]];
        pin_oe_n_q[p] <= 1'b0;
      end else begin
        pin_out_q[p]  <= 1'b0;
        pin_oe_n_q[p] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Input select fields, one per peripheral input
  // ---------------------------------------------------------------
  for (genvar n = 0; n < rpm_pkg::NUM_IN; n++) begin : g_in
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        in_sel_q[n] <= rpm_pkg::IN_SEL_RST;
      end else if (in_wr_ok && i_in_sel_wr.idx == 6'(n)) begin
        in_sel_q[n] <= i_in_sel_wr.code;
      end
    end

    // One index per input means two pins never fight; a pin may fan out
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        periph_in_q[n] <= 1'b0;
      end else if (pin_valid[in_sel_q[n]]) begin
        periph_in_q[n] <= pin_level[in_sel_q[n]];
      end else begin
        periph_in_q[n] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Routed levels of the watched pin and input, for the checks below
  logic route_pick;
  logic in_pick;
  assign route_pick = func_vec[out_sel_q[3]];
  assign in_pick    = pin_level[in_sel_q[1]];

  sequence s_out_write;
    out_wr_ok && i_out_sel_wr.idx < 6'(rpm_pkg::NUM_IO);
  endsequence

  sequence s_locked;
    i_pin_map_write_lock;
  endsequence

  property p_reset_out_null;
    @(posedge i_clk) i_rst |=> out_sel_q == '0 ##1 o_pin_oe_n == '1;
  endproperty
  a_reset_out_null: assert property (p_reset_out_null)
    else $error("output selects not null after reset");

  property p_reset_in_ones;
    @(posedge i_clk) i_rst |=>
      in_sel_q == {rpm_pkg::NUM_IN{rpm_pkg::IN_SEL_RST}};
  endproperty
  a_reset_in_ones: assert property (p_reset_in_ones)
    else $error("input selects not all ones after reset");

  property p_lock_hold;
    @(posedge i_clk) disable iff (i_rst)
      s_locked |=> $stable(out_sel_q) && $stable(in_sel_q);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("select changed while locked");

  property p_out_write;
    @(posedge i_clk) disable iff (i_rst)
      s_out_write and PIN_PRESENT[i_out_sel_wr.idx] |=>
        out_sel_q[$past(i_out_sel_wr.idx)] == $past(i_out_sel_wr.code);
  endproperty
  a_out_write: assert property (p_out_write)
    else $error("output select write lost");

  property p_absent_zero;
    @(posedge i_clk) disable iff (i_rst)
      s_out_write and !PIN_PRESENT[i_out_sel_wr.idx] |=>
        out_sel_q[$past(i_out_sel_wr.idx)] == 6'h00;
  endproperty
  a_absent_zero: assert property (p_absent_zero)
    else $error("absent pin field holds a value");

  property p_null_off;
    @(posedge i_clk) disable iff (i_rst)
      !rpm_pkg::rpm_code_listed(out_sel_q[0]) |=>
        o_pin_oe_n[0] && !o_pin_out[0];
  endproperty
  a_null_off: assert property (p_null_off)
    else $error("pin driven with null or unlisted code");

  property p_route;
    @(posedge i_clk) disable iff (i_rst)
      rpm_pkg::rpm_code_listed(out_sel_q[3]) |=>
        !o_pin_oe_n[3] && o_pin_out[3] == $past(route_pick);
  endproperty
  a_route: assert property (p_route)
    else $error("listed code not routed to pin");

  property p_in_invalid;
    @(posedge i_clk) disable iff (i_rst)
      in_sel_q[0] > rpm_pkg::LAST_PIN |=> !o_periph_in[0];
  endproperty
  a_in_invalid: assert property (p_in_invalid)
    else $error("invalid pin index fed an input");

  property p_in_route;
    @(posedge i_clk) disable iff (i_rst)
      pin_valid[in_sel_q[1]] |=>
        o_periph_in[1] == $past(in_pick);
  endproperty
  a_in_route: assert property (p_in_route)
    else $error("selected pin not routed to input");

endmodule // rpm_matrix

// ==== tb/rpm_far_model.sv ====
// Far-side model: peripheral outputs and pad levels
`timescale 1ns/1ps
module rpm_far_model (
  // Pattern select and wanted pad levels
  input  wire logic        i_phase,
  input  wire logic [43:0] i_pads,
  // Toward the matrix
  output logic      [36:1] o_func,
  output logic      [43:0] o_pads
);
  // Two inverse patterns, so a stuck or crossed route shows
  assign o_func = i_phase ? 36'h5_a5a5_a5a5 : 36'ha_5a5a_5a5a;
  // Pads are plain levels, never left floating
  assign o_pads = i_pads;
endmodule // rpm_far_model

// ==== tb/tb_rpm_matrix.sv ====
// Self-checking bench for the remappable pin matrix
`timescale 1ns/1ps
module tb_rpm_matrix;
  logic             clk = 0, rst = 1, lock = 0, phase = 0;
  rpm_pkg::rpm_wr_t owr = '0, iwr = '0;
  logic [43:0]      pads = '1, pad_w;
  logic [36:1]      func;
  logic [31:0]      pin_out, oe_n;
  logic [35:0]      per_in;
  int               n_errors = 0, check_count = 0, cycles = 0;

  rpm_far_model far (.i_phase(phase), .i_pads(pads), .o_func(func),
    .o_pads(pad_w));
  // Pin 5 and input-only pin 32 absent
  rpm_matrix #(.PIN_PRESENT(44'hffe_ffff_ffdf)) dut (.i_clk(clk),
    .i_rst(rst), .i_pin_map_write_lock(lock), .i_out_sel_wr(owr),
    .i_in_sel_wr(iwr), .i_func_out(func), .i_pin_in(pad_w),
    .o_pin_out(pin_out), .o_pin_oe_n(oe_n), .o_periph_in(per_in));

  // ---------------------------------------------
  // Clock, hang guard and helpers
  // ---------------------------------------------
  initial forever #10 clk = ~clk;
  // Whole run needs about 430 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  // Strobe drops for one edge so back-to-back writes stay clean
  task automatic wr(bit o, logic [5:0] idx, logic [5:0] code);
    if (o) owr = '{1'b1, idx, code};
    else iwr = '{1'b1, idx, code};
    tick(1);
    owr.en = 1'b0;
    iwr.en = 1'b0;
    tick(1);
  endtask
  function automatic bit listed(int c);
    return (c >= 1 && c <= 12) || (c >= 18 && c <= 25) ||
           (c >= 28 && c <= 36);
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ---------------------------------------------
  // Test sequence
  // ---------------------------------------------
  initial begin
    tick(8);
    check("rst_oe", oe_n, 32'hffff_ffff);
    check("rst_out", pin_out, 32'h0);
    check("rst_in", per_in, 36'h0);
    rst = 1'b0;
    $display("test reset done");
    // Every code on pin 3, both patterns
    for (int c = 0; c < 64; c++) begin
      wr(1, 6'd3, c[5:0]);
      for (int ph = 0; ph < 2; ph++) begin
        phase = ph[0];
        tick(2);
        check("oe3", oe_n[3], !listed(c));
        check("out3", pin_out[3], listed(c) && func[c]);
      end
    end
    $display("test codes done");
    wr(1, 6'd0, 6'd7);
    wr(1, 6'd31, 6'd7);
    check("fan", {oe_n[0], oe_n[31], pin_out[0], pin_out[31]},
      {2'b00, {2{func[7]}}});
    lock = 1'b1;
    wr(1, 6'd0, 6'd0);
    check("lock", oe_n[0], 1'b0);
    lock = 1'b0;
    wr(1, 6'd5, 6'd1);
    check("absent", oe_n[5], 1'b1);
    $display("test outputs done");
    // Pads 43, 40, 32 (absent) and 0 high
    pads = 44'h901_0000_0001;
    wr(0, 6'd0, 6'd40);
    wr(0, 6'd1, 6'd40);
    wr(0, 6'd2, 6'd32);
    wr(0, 6'd3, 6'd50);
    wr(0, 6'd4, 6'd43);
    wr(0, 6'd5, 6'd44);
    tick(4);
    check("in_map", per_in[5:0], 6'b01_0011);
    pads[40] = 1'b0;
    tick(4);
    check("in_follow", per_in[1:0], 2'b00);
    $display("test inputs done");
    rst = 1'b1;
    tick(2);
    check("rst2_oe", oe_n, 32'hffff_ffff);
    check("rst2_in", per_in, 36'h0);
    rst = 1'b0;
    tick(4);
    check("rel_oe", oe_n, 32'hffff_ffff);
    check("rel_in", per_in, 36'h0);
    $display("test second reset done");
    end_of_test();
  end
endmodule // tb_rpm_matrix
